//--- core/stt_rise_pulse.sv
// Purpose: one-cycle pulse on each rising edge of a synchronised level
// Assumes: level already in the aclk domain
// Notes:   pulse is combinational from flops
`timescale 1ns/100ps
module stt_rise_pulse (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic level,
    output logic      pulse
);

    logic prev_ff;

    // remember last level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    assign pulse = level & ~prev_ff;

endmodule : stt_rise_pulse

//--- core/stt_sync2.sv
// Purpose: two-flop synchroniser for levels entering the aclk domain
// Assumes: input changes slower than aclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module stt_sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    // two stages, sync reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule : stt_sync2

//--- core/stt_system_tick_timer.sv
// Purpose: 24-bit decrementing system tick timer behind an AXI4-Lite slave
// Assumes: 10 MHz aclk; ref_clk_pin is asynchronous; debug_halted is on aclk
// Notes:   tick_pend_set is a one-cycle request to the exception logic
//
// Behaviour
// - 24-bit down counter wrapping at zero; any current-value write clears it.
// - when enabled, decrement each reference tick; at zero reload on next tick.
// - wrap flag, status bit 16, set on each count step from 1 to 0.
// - reading the control/status register clears the wrap flag.
// - any write to current value clears counter and wrap flag.
// - after that clearing write, next timer tick loads the reload value.
// - a clearing write never raises the tick exception request.
// - current value reads return the live count at the access cycle.
// - reload of zero stops counter at zero after next wrap, enable aside.
// - no decrement while the processor is halted in debug.
// - counter runs on a reference tick: processor clock or external pin.
// - control/status holds clock select, enable, tick interrupt enable, flag.
// - calibration register is read-only and gives the ten millisecond preload.
// - registers decode at E000E010, E000E014, E000E018 and E000E01C.
// - control/status resets to 0x0, or 0x4 when clock select is fixed.
// - control/status bit 0 enables counting when one, stops it when zero.
// - bit 1 set lets a count to zero raise the tick exception request.
// - bit 2 selects external clock at zero, processor clock at one.
// - reload bits 23..0 hold reload; bits 31..24 read zero, ignore writes.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "stt_cfg.svh"

module stt_system_tick_timer #(
    parameter bit          HAS_EXT_REF    = 1'b1,
    parameter bit          CALIB_SKEW     = 1'b0,
    parameter logic [23:0] TEN_MS_PRELOAD = 24'(`STT_TEN_MS_CYCLES - 1)
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    // write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // write response channel
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // read address channel
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    // read data channel
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // timer side
    input  wire logic        ref_clk_pin,
    input  wire logic        debug_halted,
    output logic             tick_pend_set
);

    // ---------------------------------------------------------------
    // constants
    // ---------------------------------------------------------------
    localparam int          CW      = `STT_COUNT_W;
    localparam logic [31:0] CSR_RST = HAS_EXT_REF ? `STT_CSR_RESET : `STT_CSR_RESET_FIXED;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    stt_pkg::stt_ctrl_t     ctrl_ff;
    logic [CW-1:0]          reload_ff;
    logic [CW-1:0]          count_ff;
    logic                   wrap_ff;
    logic                   tick_pend_ff;

    stt_pkg::stt_wr_state_t wr_state_ff;
    logic                   aw_have_ff;
    logic                   w_have_ff;
    logic [31:0]            awaddr_ff;
    logic [31:0]            wdata_ff;
    logic [3:0]             wstrb_ff;
    logic [1:0]             bresp_ff;

    stt_pkg::stt_rd_state_t rd_state_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;

    // ---------------------------------------------------------------
    // combinational terms
    // ---------------------------------------------------------------
    logic                   ref_level;
    logic                   ref_tick;
    logic                   src_tick;
    logic                   timer_tick;
    logic                   hit_zero;
    logic                   do_wr;
    logic                   rd_take;
    logic                   csr_rd;
    logic                   cvr_wr;
    logic                   clk_sel_eff;
    stt_pkg::stt_reg_t      wr_reg;
    stt_pkg::stt_reg_t      rd_reg;
    logic [31:0]            rd_word;
    logic [31:0]            wr_mask;
    logic [31:0]            csr_word;
    logic [31:0]            calib_word;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    function automatic stt_pkg::stt_reg_t decode(input logic [31:0] addr);
        stt_pkg::stt_reg_t sel;
        sel = stt_pkg::STT_REG_NONE;
        if (addr[31:2] == `STT_ADDR_CTRL_STATUS >> 2) begin
            sel = stt_pkg::STT_REG_CSR;
        end else if (addr[31:2] == `STT_ADDR_RELOAD >> 2) begin
            sel = stt_pkg::STT_REG_RELOAD;
        end else if (addr[31:2] == `STT_ADDR_CURRENT >> 2) begin
            sel = stt_pkg::STT_REG_CURRENT;
        end else if (addr[31:2] == `STT_ADDR_CALIBRATION >> 2) begin
            sel = stt_pkg::STT_REG_CALIB;
        end
        return sel;
    endfunction : decode

    // ---------------------------------------------------------------
    // reference clock source
    // ---------------------------------------------------------------

    // external reference pin into aclk domain
    stt_sync2 #(
        .W (1)
    ) u_ref_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (ref_clk_pin),
        .q       (ref_level)
    );

    // one enable pulse per external rising edge
    stt_rise_pulse u_ref_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (ref_level),
        .pulse   (ref_tick)
    );

    // select the tick; forced to processor clock without a pin
    assign clk_sel_eff = HAS_EXT_REF ? ctrl_ff.clock_select : 1'b1;
    assign src_tick    = clk_sel_eff ? 1'b1 : ref_tick;

    // counting step: enabled and not halted
    assign timer_tick = ctrl_ff.enable & ~debug_halted & src_tick;

    // genuine 1 to 0 step, overruled by a clearing write
    assign hit_zero = timer_tick & (count_ff == CW'(1)) & ~cvr_wr;

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    assign awready = (wr_state_ff == stt_pkg::STT_WR_IDLE) & ~aw_have_ff;
    assign wready  = (wr_state_ff == stt_pkg::STT_WR_IDLE) & ~w_have_ff;
    assign bvalid  = (wr_state_ff == stt_pkg::STT_WR_RESP);
    assign bresp   = bresp_ff;
    assign do_wr   = (wr_state_ff == stt_pkg::STT_WR_IDLE) & aw_have_ff & w_have_ff;
    assign wr_reg  = decode(awaddr_ff);
    assign cvr_wr  = do_wr & (wr_reg == stt_pkg::STT_REG_CURRENT);

    // byte lanes to bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_mask[i*8 +: 8] = {8{wstrb_ff[i]}};
        end
    end

    // hold address and data until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awaddr_ff  <= 32'h0000_0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else if (do_wr) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff  <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_ff <= 1'b1;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
        end
    end

    // response state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= stt_pkg::STT_WR_IDLE;
            bresp_ff    <= `STT_RESP_OKAY;
        end else begin
            unique case (wr_state_ff)
                stt_pkg::STT_WR_IDLE: begin
                    if (do_wr) begin
                        wr_state_ff <= stt_pkg::STT_WR_RESP;
                        bresp_ff    <= (wr_reg == stt_pkg::STT_REG_NONE) ?
                                       `STT_RESP_SLVERR : `STT_RESP_OKAY;
                    end
                end
                stt_pkg::STT_WR_RESP: begin
                    if (bready) begin
                        wr_state_ff <= stt_pkg::STT_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // software-written registers
    // ---------------------------------------------------------------

    // control bits, low byte lane only; reserved bits not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= stt_pkg::stt_ctrl_t'(CSR_RST[2:0]);
        end else if (do_wr && wr_reg == stt_pkg::STT_REG_CSR && wstrb_ff[0]) begin
            ctrl_ff.enable          <= wdata_ff[`STT_CSR_ENABLE_BIT];
            ctrl_ff.tick_irq_enable <= wdata_ff[`STT_CSR_TICK_IRQ_ENABLE_BIT];
            if (HAS_EXT_REF) begin
                ctrl_ff.clock_select <= wdata_ff[`STT_CSR_CLKSEL_BIT];
            end
        end
    end

    // reload value, bits 23..0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_ff <= `STT_COUNT_RESET;
        end else if (do_wr && wr_reg == stt_pkg::STT_REG_RELOAD) begin
            reload_ff <= (wdata_ff[CW-1:0] & wr_mask[CW-1:0]) |
                         (reload_ff & ~wr_mask[CW-1:0]);
        end
    end

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------

    // clear on write, reload at zero, else count down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= `STT_COUNT_RESET;
        end else if (cvr_wr) begin
            count_ff <= `STT_COUNT_RESET;
        end else if (timer_tick) begin
            if (count_ff == `STT_COUNT_RESET) begin
                count_ff <= reload_ff;
            end else begin
                count_ff <= count_ff - CW'(1);
            end
        end
    end

    // wrap flag: set beats a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_ff <= 1'b0;
        end else if (hit_zero) begin
            wrap_ff <= 1'b1;
        end else if (cvr_wr || csr_rd) begin
            wrap_ff <= 1'b0;
        end
    end

    // tick exception request pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_pend_ff <= 1'b0;
        end else begin
            tick_pend_ff <= hit_zero & ctrl_ff.tick_irq_enable;
        end
    end

    assign tick_pend_set = tick_pend_ff;

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    assign arready = (rd_state_ff == stt_pkg::STT_RD_IDLE);
    assign rvalid  = (rd_state_ff == stt_pkg::STT_RD_DATA);
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign rd_take = arvalid & arready;
    assign rd_reg  = decode(araddr);
    assign csr_rd  = rd_take & (rd_reg == stt_pkg::STT_REG_CSR);

    // status word, reserved bits zero
    always_comb begin
        csr_word                        = 32'h0000_0000;
        csr_word[`STT_CSR_ENABLE_BIT]   = ctrl_ff.enable;
        csr_word[`STT_CSR_TICK_IRQ_ENABLE_BIT]  = ctrl_ff.tick_irq_enable;
        csr_word[`STT_CSR_CLKSEL_BIT]   = clk_sel_eff;
        csr_word[`STT_CSR_WRAP_BIT]     = wrap_ff;
    end

    // calibration word, constant
    always_comb begin
        calib_word                      = 32'h0000_0000;
        calib_word[CW-1:0]              = TEN_MS_PRELOAD;
        calib_word[`STT_CAL_SKEW_BIT]   = CALIB_SKEW;
        calib_word[`STT_CAL_NOREF_BIT]  = ~HAS_EXT_REF;
    end

    // read mux, live count
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_reg)
            stt_pkg::STT_REG_CSR:     rd_word = csr_word;
            stt_pkg::STT_REG_RELOAD:  rd_word = {8'h00, reload_ff};
            stt_pkg::STT_REG_CURRENT: rd_word = {8'h00, count_ff};
            stt_pkg::STT_REG_CALIB:   rd_word = calib_word;
            stt_pkg::STT_REG_NONE:    rd_word = 32'h0000_0000;
        endcase
    end

    // capture answer at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= stt_pkg::STT_RD_IDLE;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= `STT_RESP_OKAY;
        end else begin
            unique case (rd_state_ff)
                stt_pkg::STT_RD_IDLE: begin
                    if (rd_take) begin
                        rd_state_ff <= stt_pkg::STT_RD_DATA;
                        rdata_ff    <= rd_word;
                        rresp_ff    <= (rd_reg == stt_pkg::STT_REG_NONE) ?
                                       `STT_RESP_SLVERR : `STT_RESP_OKAY;
                    end
                end
                stt_pkg::STT_RD_DATA: begin
                    if (rready) begin
                        rd_state_ff <= stt_pkg::STT_RD_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : stt_system_tick_timer

//--- pkg/stt_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the tick timer
// Assumes: 10 MHz aclk, word-aligned registers on a 32-bit bus
// Notes:   definitions only
`ifndef STT_CFG_SVH
`define STT_CFG_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define STT_ADDR_CTRL_STATUS  32'hE000_E010
`define STT_ADDR_RELOAD       32'hE000_E014
`define STT_ADDR_CURRENT      32'hE000_E018
`define STT_ADDR_CALIBRATION  32'hE000_E01C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define STT_CSR_ENABLE_BIT    0
`define STT_CSR_TICK_IRQ_ENABLE_BIT   1
`define STT_CSR_CLKSEL_BIT    2
`define STT_CSR_WRAP_BIT      16
`define STT_CAL_NOREF_BIT     31
`define STT_CAL_SKEW_BIT      30
`define STT_COUNT_W           24

// ---------------------------------------------------------------
// reset values and answers
// ---------------------------------------------------------------
`define STT_CSR_RESET         32'h0000_0000
`define STT_CSR_RESET_FIXED   32'h0000_0004
`define STT_COUNT_RESET       24'h00_0000
`define STT_RESP_OKAY         2'h0
`define STT_RESP_SLVERR       2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define STT_CLK_PERIOD_NS     100
`define STT_TEN_MS_NS         10000000
`define STT_TEN_MS_CYCLES     (`STT_TEN_MS_NS / `STT_CLK_PERIOD_NS)

`endif

//--- pkg/stt_pkg.sv
// Purpose: types shared by the tick timer files
// Assumes: constants live in stt_cfg.svh
// Notes:   no imports anywhere, always stt_pkg::name
package stt_pkg;

    // ---------------------------------------------------------------
    // control fields, bit 2 down to bit 0
    // ---------------------------------------------------------------
    typedef struct packed {
        logic clock_select;
        logic tick_irq_enable;
        logic enable;
    } stt_ctrl_t;

    // register selected by an address
    typedef enum logic [2:0] {
        STT_REG_CSR,
        STT_REG_RELOAD,
        STT_REG_CURRENT,
        STT_REG_CALIB,
        STT_REG_NONE
    } stt_reg_t;

    // write channel state
    typedef enum logic {
        STT_WR_IDLE,
        STT_WR_RESP
    } stt_wr_state_t;

    // read channel state
    typedef enum logic {
        STT_RD_IDLE,
        STT_RD_DATA
    } stt_rd_state_t;

endpackage : stt_pkg

//--- tb/stt_system_tick_timer_asserts.sv
// Purpose: port checker for the tick timer bus answers and tick pulse
// Assumes: bound into stt_system_tick_timer, one clock domain
// Notes:   sees top-level ports only
`timescale 1ns/100ps
`include "stt_cfg.svh"
module stt_system_tick_timer_asserts #(
    parameter bit          HAS_EXT_REF    = 1'b1,
    parameter bit          CALIB_SKEW     = 1'b0,
    parameter logic [23:0] TEN_MS_PRELOAD = 24'h00_0000
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        debug_halted,
    input wire logic        tick_pend_set
);
    // read address taken at this edge
    logic ar_take;
    assign ar_take = arvalid && arready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_rd_unmapped;
        ar_take && araddr[31:4] != 28'hE000_E01 |=>
            rvalid && rresp == `STT_RESP_SLVERR && rdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("bad unmapped read");
    property p_calib;
        ar_take && araddr == `STT_ADDR_CALIBRATION |=>
            rdata == {!HAS_EXT_REF, CALIB_SKEW, 6'h00, TEN_MS_PRELOAD};
    endproperty
    a_calib: assert property (p_calib) else $error("bad calibration word");
    property p_ctrl_rsv;
        ar_take && araddr == `STT_ADDR_CTRL_STATUS |=> rdata[31:17] == 15'h0000
            && rdata[15:3] == 13'h0000 && (HAS_EXT_REF || rdata[2]);
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("bad status bits");
    property p_count_rsv;
        ar_take && (araddr == `STT_ADDR_RELOAD || araddr == `STT_ADDR_CURRENT) |=>
            rdata[31:24] == 8'h00 && rresp == `STT_RESP_OKAY;
    endproperty
    a_count_rsv: assert property (p_count_rsv) else $error("bad count word");
    property p_rd_answer;
        ar_take |=> rvalid && !arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
    property p_rd_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer moved");
    property p_pulse;
        tick_pend_set |=> !tick_pend_set;
    endproperty
    a_pulse: assert property (p_pulse) else $error("tick request too long");
    property p_halt;
        tick_pend_set |-> !$past(debug_halted);
    endproperty
    a_halt: assert property (p_halt) else $error("tick while halted");
endmodule : stt_system_tick_timer_asserts

bind stt_system_tick_timer stt_system_tick_timer_asserts #(
    .HAS_EXT_REF(HAS_EXT_REF), .CALIB_SKEW(CALIB_SKEW), .TEN_MS_PRELOAD(TEN_MS_PRELOAD)
) u_chk (.aclk, .aresetn, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .bresp, .bvalid, .bready, .debug_halted, .tick_pend_set);

//--- tb/stt_system_tick_timer_test.sv
// Purpose: register-level test of the tick timer over AXI4-Lite
// Assumes: default parameters, aclk 10 MHz
// Notes:   debug_halted freezes the count between reads
`timescale 1ns/100ps
`include "stt_cfg.svh"
module stt_system_tick_timer_test;
    localparam logic [31:0] A_CS = `STT_ADDR_CTRL_STATUS;
    localparam logic [31:0] A_RV = `STT_ADDR_RELOAD;
    localparam logic [31:0] A_CV = `STT_ADDR_CURRENT;
    localparam logic [31:0] A_CB = `STT_ADDR_CALIBRATION;
    localparam logic [31:0] A_NO = 32'hE000_E020;
    localparam logic [31:0] CAL  = {8'h00, 24'(`STT_TEN_MS_CYCLES - 1)};
    localparam logic [1:0]  OK   = `STT_RESP_OKAY;
    localparam logic [1:0]  ER   = `STT_RESP_SLVERR;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        ref_clk_pin, debug_halted, awready, wready, bvalid, arready;
    logic        rvalid, tick_pend_set;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp;
    int          failures, check_count, pulses;

    // design under test, strobes and protection tied
    stt_system_tick_timer DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .ref_clk_pin, .debug_halted, .tick_pend_set);

    // clock, 100 ns period
    always #50 aclk = ~aclk;
    // count tick requests
    always @(posedge aclk) if (tick_pend_set === 1'b1) pulses <= pulses + 1;

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one write, each channel released when taken, bready up from the start
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ha, hw, hb;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r  = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            failures++;
            wrap_up();
        end
    endtask : wr
    // one read, rready up from the start until rvalid is taken
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ha, hr;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hr) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            failures++;
            wrap_up();
        end
    endtask : rd
    task automatic wc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0000_0000, r}, {30'h0000_0000, er});
    endtask : wc
    task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0000_0000, r}, {30'h0000_0000, er});
    endtask : rc
    // let the counter step for exactly k edges
    task automatic run(input int k);
        @(posedge aclk);
        debug_halted <= 1'b0;
        repeat (k) @(posedge aclk);
        debug_halted <= 1'b1;
    endtask : run

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ref_clk_pin} = 8'h00;
        {awaddr, wdata, araddr} = {3{32'h0000_0000}};
        debug_halted = 1'b1;
        failures = 0;
        check_count = 0;
        pulses = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_CS, 32'h0000_0000, OK);
        rc(A_CB, CAL, OK);
        wc(A_CB, 32'h0000_0000, OK);
        rc(A_CB, CAL, OK);
        wc(A_RV, 32'hFFFF_FFFF, OK);
        rc(A_RV, 32'h00FF_FFFF, OK);
        wc(A_CS, 32'hFFFF_FFF6, OK);
        rc(A_CS, 32'h0000_0006, OK);
        rc(A_NO, 32'h0000_0000, ER);
        wc(A_NO, 32'h0000_0001, ER);
        wc(A_RV, 32'h0000_0005, OK);
        wc(A_CV, 32'h0000_00AB, OK);
        rc(A_CV, 32'h0000_0000, OK);
        wc(A_CS, 32'h0000_0007, OK);
        repeat (5) @(posedge aclk);
        rc(A_CV, 32'h0000_0000, OK);
        run(1);
        rc(A_CV, 32'h0000_0005, OK);
        run(2);
        rc(A_CV, 32'h0000_0003, OK);
        run(3);
        rc(A_CV, 32'h0000_0000, OK);
        rc(A_CS, 32'h0001_0007, OK);
        chk(32'(pulses), 32'h0000_0001);
        rc(A_CS, 32'h0000_0007, OK);
        run(1);
        rc(A_CV, 32'h0000_0005, OK);
        run(5);
        wc(A_CV, 32'h0000_1234, OK);
        rc(A_CS, 32'h0000_0007, OK);
        chk(32'(pulses), 32'h0000_0002);
        // tick interrupt off, then reload of zero
        wc(A_CS, 32'h0000_0005, OK);
        run(1);
        wc(A_RV, 32'h0000_0000, OK);
        run(7);
        rc(A_CV, 32'h0000_0000, OK);
        rc(A_CS, 32'h0001_0005, OK);
        chk(32'(pulses), 32'h0000_0002);
        run(3);
        rc(A_CS, 32'h0000_0005, OK);
        // disabled counter stays put
        wc(A_RV, 32'h0000_0005, OK);
        wc(A_CS, 32'h0000_0004, OK);
        wc(A_CV, 32'h0000_0000, OK);
        run(4);
        rc(A_CV, 32'h0000_0000, OK);
        // external reference, two rising edges
        wc(A_CS, 32'h0000_0001, OK);
        debug_halted <= 1'b0;
        repeat (2) begin
            repeat (8) @(posedge aclk);
            ref_clk_pin <= 1'b1;
            repeat (8) @(posedge aclk);
            ref_clk_pin <= 1'b0;
        end
        repeat (8) @(posedge aclk);
        debug_halted <= 1'b1;
        rc(A_CV, 32'h0000_0004, OK);
        rc(A_CS, 32'h0000_0001, OK);
        wrap_up();
    end
endmodule : stt_system_tick_timer_test
